/* File: core/bmu_pkg.sv */
/*
  shared constants and types of the binary multiply / divide / step unit.
  assumes one 100 MHz clock and an external sequencer that owns memory.
*/
package bmu_pkg;

  localparam int ACC_W  = 32;
  localparam int OPD_W  = 16;
  localparam int ADDR_W = 16;
  localparam int CNT_W  = 6;

  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [OPD_W-1:0] ONE_W   = 16'h0001;
  localparam logic [OPD_W-1:0] ZERO_W  = 16'h0000;

  // operation codes on the request port
  typedef enum logic [1:0] {
    BMU_OP_MUL = 2'b00,
    BMU_OP_DIV = 2'b01,
    BMU_OP_INC = 2'b10,
    BMU_OP_DEC = 2'b11
  } bmu_op_t;

  // operand source
  typedef enum logic [1:0] {
    BMU_SRC_IMM = 2'b00,
    BMU_SRC_DIR = 2'b01,
    BMU_SRC_PTR = 2'b10
  } bmu_src_t;

  typedef enum logic [2:0] {
    BMU_ST_IDLE = 3'b000,
    BMU_ST_PRD  = 3'b001,
    BMU_ST_RD   = 3'b010,
    BMU_ST_DIV  = 3'b011,
    BMU_ST_WR   = 3'b100,
    BMU_ST_DONE = 3'b101
  } bmu_state_t;

endpackage

/* File: core/bmu_divider.sv */
/*
  restoring divider, one quotient bit per cycle, 32 by 16 unsigned.
  assumes start only while idle and a divisor that is not zero.
*/
`timescale 1ns/1ps
module bmu_divider #(
  parameter int DW = 32,
  parameter int VW = 16,
  parameter int CW = 6
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  // request
  input  wire logic          start_i,
  input  wire logic [DW-1:0] dividend_i,
  input  wire logic [VW-1:0] divisor_i,
  // answer
  output logic               done_o,
  output logic [DW-1:0]      quot_o,
  output logic [VW-1:0]      rem_o
);
  logic          busy;
  logic [CW-1:0] cnt;
  logic [VW:0]   part;
  logic [VW:0]   trial;
  logic [VW-1:0] dvs;
  logic [VW:0]   shifted;

  assign shifted = {part[VW-1:0], quot_o[DW-1]};
  assign trial   = shifted - {1'b0, dvs};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy   <= 1'b0;
      cnt    <= '0;
      part   <= '0;
      dvs    <= '0;
      quot_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy) begin
        busy   <= 1'b1;
        cnt    <= CW'(DW);
        part   <= '0;
        dvs    <= divisor_i;
        quot_o <= dividend_i;
      end else if (busy) begin
        if (trial[VW]) begin
          part   <= shifted;
          quot_o <= {quot_o[DW-2:0], 1'b0};
        end else begin
          part   <= trial;
          quot_o <= {quot_o[DW-2:0], 1'b1};
        end
        cnt <= cnt - CW'(1);
        if (cnt == CW'(1)) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  assign rem_o = part[VW-1:0];

  // ****************************************
  // checks
  // ****************************************
  div_latency_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (start_i && !busy) |-> ##33 done_o)
    else $error("divider did not finish in 33 cycles");
endmodule

/* File: core/bmu_top.sv */
/*
  binary multiply, divide, increment and decrement unit on a 32-bit
  accumulator. assumes a sequencer that issues one request at a time and
  a word memory answering reads in the same cycle as the read strobe.
*/
`timescale 1ns/1ps
module bmu_top (
  // clock and reset
  input  wire logic                         CLOCK_I,
  input  wire logic                         NRST_I,
  // request from sequencer
  input  wire logic                         REQ_I,
  input  wire bmu_pkg::bmu_op_t             OP_I,
  input  wire bmu_pkg::bmu_src_t            SRC_I,
  input  wire logic [bmu_pkg::OPD_W-1:0]    ARG_I,
  // accumulator load
  input  wire logic                         ACC_LOAD_I,
  input  wire logic [bmu_pkg::ACC_W-1:0]    ACC_DATA_I,
  // word memory
  output logic                              MEM_RD_O,
  output logic                              MEM_WR_O,
  output logic [bmu_pkg::ADDR_W-1:0]        MEM_ADDR_O,
  output logic [bmu_pkg::OPD_W-1:0]         MEM_WDATA_O,
  input  wire logic [bmu_pkg::OPD_W-1:0]    MEM_RDATA_I,
  // stack push of remainder
  output logic                              STACK_PUSH_O,
  output logic [bmu_pkg::OPD_W-1:0]         STACK_DATA_O,
  // results
  output logic                              BUSY_O,
  output logic                              DONE_O,
  output logic [bmu_pkg::ACC_W-1:0]         ACC_O,
  output logic                              ZERO_RESULT_FLAG_O,
  output logic                              NEGATIVE_RESULT_FLAG_O,
  output logic                              OPERAND_RANGE_FLAG_O
);
  import bmu_pkg::*;

  bmu_state_t        state;
  bmu_op_t           op;
  logic [OPD_W-1:0]  arg;
  logic [OPD_W-1:0]  opnd;
  logic              div_start;
  logic              div_done;
  logic [ACC_W-1:0]  div_quot;
  logic [OPD_W-1:0]  div_rem;
  logic [ACC_W-1:0]  product;
  logic [OPD_W-1:0]  step;

  // zero-extended unsigned product fills all 32 bits
  assign product = ACC_W'(ACC_O[OPD_W-1:0]) * ACC_W'(opnd);
  assign step    = (op == BMU_OP_INC) ? opnd + ONE_W
                                      : opnd - ONE_W;

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= BMU_ST_IDLE;
      op    <= BMU_OP_MUL;
      arg   <= ZERO_W;
    end else begin
      unique case (state)
        BMU_ST_IDLE: begin
          if (REQ_I) begin
            op  <= OP_I;
            arg <= ARG_I;
            if (SRC_I == BMU_SRC_PTR) begin
              state <= BMU_ST_PRD;
            end else if (SRC_I == BMU_SRC_DIR ||
                         OP_I == BMU_OP_INC || OP_I == BMU_OP_DEC) begin
              state <= BMU_ST_RD;
            end else if (OP_I == BMU_OP_DIV) begin
              state <= BMU_ST_DIV;
            end else begin
              state <= BMU_ST_DONE;
            end
          end
        end
        BMU_ST_PRD: begin
          arg   <= MEM_RDATA_I;
          state <= BMU_ST_RD;
        end
        BMU_ST_RD: begin
          if (op == BMU_OP_INC || op == BMU_OP_DEC) begin
            state <= BMU_ST_WR;
          end else if (op == BMU_OP_DIV) begin
            state <= BMU_ST_DIV;
          end else begin
            state <= BMU_ST_DONE;
          end
        end
        BMU_ST_DIV: begin
          // zero divisor ends at once
          if (opnd == ZERO_W || div_done) begin
            state <= BMU_ST_DONE;
          end
        end
        BMU_ST_WR:   state <= BMU_ST_DONE;
        BMU_ST_DONE: state <= BMU_ST_IDLE;
        default:     state <= BMU_ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // operand capture
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      opnd <= ZERO_W;
    end else if (state == BMU_ST_IDLE && REQ_I) begin
      opnd <= ARG_I;
    end else if (state == BMU_ST_RD) begin
      opnd <= MEM_RDATA_I;
    end
  end

  assign div_start = (state == BMU_ST_DIV) && (opnd != ZERO_W) && !BUSY_O;

  bmu_divider #(
    .DW (ACC_W),
    .VW (OPD_W),
    .CW (CNT_W)
  ) u_div (
    .clk_i      (CLOCK_I),
    .nrst_i     (NRST_I),
    .start_i    (div_start),
    .dividend_i (ACC_O),
    .divisor_i  (opnd),
    .done_o     (div_done),
    .quot_o     (div_quot),
    .rem_o      (div_rem)
  );

  // ****************************************
  // memory port
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      MEM_RD_O    <= 1'b0;
      MEM_WR_O    <= 1'b0;
      MEM_ADDR_O  <= ZERO_W;
      MEM_WDATA_O <= ZERO_W;
    end else begin
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
      if (state == BMU_ST_IDLE && REQ_I && SRC_I != BMU_SRC_IMM) begin
        MEM_RD_O   <= 1'b1;
        MEM_ADDR_O <= ARG_I;
      end else if (state == BMU_ST_PRD) begin
        MEM_RD_O   <= 1'b1;
        MEM_ADDR_O <= MEM_RDATA_I;
      end else if (state == BMU_ST_WR) begin
        MEM_WR_O    <= 1'b1;
        MEM_WDATA_O <= step;
        MEM_ADDR_O  <= arg;
      end
    end
  end

  // ****************************************
  // accumulator, stack and flags
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ACC_O        <= ACC_RST;
      STACK_PUSH_O <= 1'b0;
      STACK_DATA_O <= ZERO_W;
    end else begin
      STACK_PUSH_O <= 1'b0;
      if (ACC_LOAD_I && state == BMU_ST_IDLE) begin
        ACC_O <= ACC_DATA_I;
      end else if (state == BMU_ST_DONE && op == BMU_OP_MUL) begin
        ACC_O <= product;
      end else if (state == BMU_ST_DIV && div_done) begin
        ACC_O        <= div_quot;
        STACK_PUSH_O <= 1'b1;
        STACK_DATA_O <= div_rem;
      end
    end
  end

  // flags change only on their own instructions, else they hold
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ZERO_RESULT_FLAG_O     <= 1'b0;
      NEGATIVE_RESULT_FLAG_O <= 1'b0;
      OPERAND_RANGE_FLAG_O   <= 1'b0;
    end else if (state == BMU_ST_DONE && op == BMU_OP_MUL) begin
      ZERO_RESULT_FLAG_O     <= (product == ACC_RST);
      NEGATIVE_RESULT_FLAG_O <= product[ACC_W-1];
    end else if (state == BMU_ST_DIV && opnd == ZERO_W) begin
      OPERAND_RANGE_FLAG_O <= 1'b1;
    end else if (state == BMU_ST_DIV && div_done) begin
      OPERAND_RANGE_FLAG_O   <= 1'b0;
      ZERO_RESULT_FLAG_O     <= (div_quot == ACC_RST);
      NEGATIVE_RESULT_FLAG_O <= div_quot[ACC_W-1];
    end else if (state == BMU_ST_WR && op == BMU_OP_DEC) begin
      ZERO_RESULT_FLAG_O <= (step == ZERO_W);
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
    end else begin
      BUSY_O <= div_start || (BUSY_O && !div_done);
      DONE_O <= (state == BMU_ST_DONE);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  mul_result_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_DONE && op == BMU_OP_MUL && !ACC_LOAD_I)
    |=> ACC_O == $past(product))
    else $error("product not written to accumulator");
  mul_zero_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_DONE && op == BMU_OP_MUL)
    |=> ZERO_RESULT_FLAG_O == (ACC_O == ACC_RST))
    else $error("zero flag disagrees with product");
  neg_flag_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_DONE && op == BMU_OP_MUL)
    |=> NEGATIVE_RESULT_FLAG_O == ACC_O[ACC_W-1])
    else $error("negative flag disagrees with msb");
  div_zero_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_DIV && opnd == ZERO_W)
    |=> OPERAND_RANGE_FLAG_O && $stable(ACC_O) && !STACK_PUSH_O)
    else $error("zero divisor mishandled");
  div_push_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_DIV && div_done) |=> STACK_PUSH_O ##1 !STACK_PUSH_O)
    else $error("remainder push missing");
  div_bound_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_DIV) |-> ##[1:40] (state == BMU_ST_DONE))
    else $error("divide did not end");
  inc_write_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_WR && op == BMU_OP_INC)
    |=> MEM_WR_O && MEM_WDATA_O == $past(opnd) + ONE_W)
    else $error("increment write wrong");
  dec_write_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_WR && op == BMU_OP_DEC)
    |=> MEM_WR_O && MEM_WDATA_O == $past(opnd) - ONE_W
        && ZERO_RESULT_FLAG_O == (MEM_WDATA_O == ZERO_W))
    else $error("decrement write wrong");
  flag_hold_a: assert property (
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (state == BMU_ST_IDLE) |=> $stable(OPERAND_RANGE_FLAG_O))
    else $error("range flag changed while idle");
endmodule

/* File: verif/bmu_mem_model.sv */
/*
  word memory model that answers the muldiv unit's reads and writes.
  assumes registered one-cycle read and write strobes from the unit.
*/
`timescale 1ns/1ps
module bmu_mem_model (
  // clock
  input  wire logic        clk_i,
  // access from the unit
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [0:255];
  logic        rd_q = 1'b0;
  logic [15:0] junk = 16'ha5a5;

  // ********************************
  // storage
  // ********************************
  always @(posedge clk_i) begin
    rd_q <= rd_i;
    junk <= ~junk;
    if (wr_i) begin
      mem[addr_i[7:0]] <= wdata_i;
    end
  end

  // data stands in the strobe cycle and the next; a toggling pattern
  // otherwise, so a late sample cannot pass by chance
  assign rdata_o = (rd_i || rd_q) ? mem[addr_i[7:0]] : junk;
endmodule

/* File: verif/test_binary_muldiv_incdec_unit.sv */
/*
  self-checking bench of the binary multiply, divide and step unit.
  assumes the memory model beside it and the unit's shared package.
*/
`timescale 1ns/1ps
module test_binary_muldiv_incdec_unit;
  import bmu_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        req = 1'b0;
  bmu_op_t     op = BMU_OP_MUL;
  bmu_src_t    src = BMU_SRC_IMM;
  logic [15:0] arg = 16'h0000;
  logic        acc_load = 1'b0;
  logic [31:0] acc_data = 32'h0000_0000;
  logic        mem_rd, mem_wr, push, busy, done, zf, nf, rf;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, stack_data, last_rem;
  logic [31:0] acc;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          n_push = 0;
  int          n_busy = 0;

  always #5 clock = ~clock;

  bmu_top DUT (
    .CLOCK_I(clock), .NRST_I(nrst), .REQ_I(req), .OP_I(op), .SRC_I(src),
    .ARG_I(arg), .ACC_LOAD_I(acc_load), .ACC_DATA_I(acc_data),
    .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr), .MEM_ADDR_O(mem_addr),
    .MEM_WDATA_O(mem_wdata), .MEM_RDATA_I(mem_rdata),
    .STACK_PUSH_O(push), .STACK_DATA_O(stack_data), .BUSY_O(busy),
    .DONE_O(done), .ACC_O(acc), .ZERO_RESULT_FLAG_O(zf),
    .NEGATIVE_RESULT_FLAG_O(nf), .OPERAND_RANGE_FLAG_O(rf));

  bmu_mem_model u_mem (
    .clk_i(clock), .rd_i(mem_rd), .wr_i(mem_wr), .addr_i(mem_addr),
    .wdata_i(mem_wdata), .rdata_o(mem_rdata));

  // remainder pushes and divider busy cycles seen on the ports
  always @(posedge clock) begin
    if (push === 1'b1) begin
      n_push++;
      last_rem = stack_data;
    end
    if (busy === 1'b1) begin
      n_busy++;
    end
  end

  // ********************************
  // shared tasks
  // ********************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task flags(input logic [2:0] e);
    chk({29'h0, zf, nf, rf}, {29'h0, e});
  endtask

  task load_acc(input logic [31:0] v);
    @(negedge clock);
    acc_load = 1'b1;
    acc_data = v;
    @(negedge clock);
    acc_load = 1'b0;
  endtask

  task run_op(input bmu_op_t o, input bmu_src_t s, input logic [15:0] a);
    int k;
    @(negedge clock);
    req = 1'b1;
    op = o;
    src = s;
    arg = a;
    @(negedge clock);
    req = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    if (k >= 100) begin
      n_mismatch++;
      $display("mismatch at %0t: no done", $time);
    end
  endtask

  // ********************************
  // scenarios
  // ********************************
  task t_mul;
    load_acc(32'h0000_ffff);
    run_op(BMU_OP_MUL, BMU_SRC_IMM, 16'hffff);
    chk(acc, 32'hfffe_0001);
    flags(3'b010);
    load_acc(32'habcd_0003);
    run_op(BMU_OP_MUL, BMU_SRC_IMM, 16'h0005);
    chk(acc, 32'h0000_000f);
    flags(3'b000);
    run_op(BMU_OP_MUL, BMU_SRC_IMM, 16'h0000);
    flags(3'b100);
  endtask

  task t_mul_mem;
    u_mem.mem[8'h10] = 16'h0003;
    u_mem.mem[8'h20] = 16'h0010;
    load_acc(32'h0000_0007);
    run_op(BMU_OP_MUL, BMU_SRC_DIR, 16'h0010);
    chk(acc, 32'h0000_0015);
    run_op(BMU_OP_MUL, BMU_SRC_PTR, 16'h0020);
    chk(acc, 32'h0000_003f);
  endtask

  task t_div;
    int p0;
    int b0;
    u_mem.mem[8'h11] = 16'h0001;
    u_mem.mem[8'h12] = 16'h0005;
    u_mem.mem[8'h21] = 16'h0012;
    load_acc(32'h0001_0005);
    p0 = n_push;
    b0 = n_busy;
    run_op(BMU_OP_DIV, BMU_SRC_IMM, 16'h0010);
    chk(acc, 32'h0000_1000);
    chk(32'(n_busy - b0), 32'(ACC_W + 1));
    chk({31'h0, busy}, 32'h0);
    chk(32'(n_push - p0), 32'h1);
    chk({16'h0, last_rem}, 32'h5);
    flags(3'b000);
    load_acc(32'h8000_0003);
    run_op(BMU_OP_DIV, BMU_SRC_DIR, 16'h0011);
    chk(acc, 32'h8000_0003);
    flags(3'b010);
    load_acc(32'h0000_0003);
    run_op(BMU_OP_DIV, BMU_SRC_PTR, 16'h0021);
    chk(acc, 32'h0000_0000);
    chk({16'h0, last_rem}, 32'h3);
    flags(3'b100);
  endtask

  task t_div_zero;
    int p0;
    int b0;
    load_acc(32'h1234_5678);
    p0 = n_push;
    b0 = n_busy;
    run_op(BMU_OP_DIV, BMU_SRC_IMM, 16'h0000);
    chk(acc, 32'h1234_5678);
    chk(32'(n_push - p0), 32'h0);
    chk(32'(n_busy - b0), 32'h0);
    chk({31'h0, rf}, 32'h1);
    run_op(BMU_OP_DIV, BMU_SRC_IMM, 16'h0002);
    chk(acc, 32'h091a_2b3c);
    chk({31'h0, rf}, 32'h0);
  endtask

  task t_step;
    u_mem.mem[8'h30] = 16'hffff;
    u_mem.mem[8'h31] = 16'h0001;
    u_mem.mem[8'h32] = 16'h0031;
    run_op(BMU_OP_INC, BMU_SRC_DIR, 16'h0030);
    chk({16'h0, u_mem.mem[8'h30]}, 32'h0);
    chk({31'h0, zf}, 32'h0);
    run_op(BMU_OP_DEC, BMU_SRC_DIR, 16'h0031);
    chk({16'h0, u_mem.mem[8'h31]}, 32'h0);
    chk({31'h0, zf}, 32'h1);
    run_op(BMU_OP_DEC, BMU_SRC_PTR, 16'h0032);
    chk({16'h0, u_mem.mem[8'h31]}, 32'hffff);
    chk({31'h0, zf}, 32'h0);
  endtask

  // ********************************
  // main sequence and watchdog
  // ********************************
  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    t_mul();
    t_mul_mem();
    t_div();
    t_div_zero();
    t_step();
    report_and_stop();
  end

  initial begin
    #50000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
